// [rtl/cvr_pkg.sv]
/*
  Shared constants for the comparator and voltage reference control block:
  register offsets, field positions, reset values and the comparator modes.
  Assumes a 32-bit classic Wishbone bus with byte addresses; every register
  takes one aligned word and carries 8 bits in the low byte.
*/
package cvr_pkg;

  // Register byte offsets.
  localparam logic [7:0] CMP_CTRL_OFS = 8'h00;
  localparam logic [7:0] REF_CTRL_OFS = 8'h04;
  localparam logic [7:0] FLAGS_OFS = 8'h08;
  localparam logic [7:0] ENABLES_OFS = 8'h0C;
  localparam logic [7:0] PRIORITY_OFS = 8'h10;

  // Comparator control fields.
  localparam int SECOND_RESULT_BIT = 7;
  localparam int FIRST_RESULT_BIT = 6;
  localparam int SECOND_INVERT_BIT = 5;
  localparam int FIRST_INVERT_BIT = 4;
  localparam int INPUT_SWITCH_BIT = 3;
  localparam int MODE_MSB = 2;

  // Reference control fields.
  localparam int REF_POWER_BIT = 7;
  localparam int REF_PIN_OE_BIT = 6;
  localparam int REF_RANGE_BIT = 5;
  localparam int REF_SOURCE_BIT = 4;
  localparam int REF_LEVEL_MSB = 3;

  // Interrupt flag, enable and priority bit position.
  localparam int CMP_IRQ_BIT = 6;

  // Reset values.
  localparam logic [7:0] CMP_CTRL_RST = 8'h00;
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [7:0] PRIORITY_RST = 8'h40;

  // Comparator modes named by this block.
  typedef enum logic [2:0] {
    CVR_MODE_RESET = 3'b000,
    CVR_MODE_INTREF = 3'b110,
    CVR_MODE_OFF = 3'b111
  } cvr_mode_t;

endpackage : cvr_pkg

// [rtl/cvr_result_latch.sv]
/*
  Holds the comparator results last seen by software and flags a mismatch
  against the live, polarity-corrected results.
  Assumes results are synchronous to clk_i and that capture_i pulses on each
  software access of the comparator control register.
*/
`timescale 1ns/1ps
module cvr_result_latch #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Live results and capture strobe
  input wire logic [N-1:0] result_i,
  input wire logic capture_i,
  // Mismatch indication
  output logic mismatch_o
);

  logic [N-1:0] seen_q;
  logic [N-1:0] diff;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          seen_q[g] <= 1'b0;
        end else if (capture_i) begin
          seen_q[g] <= result_i[g];
        end
      end
      assign diff[g] = seen_q[g] ^ result_i[g];
    end
  endgenerate

  // A mismatch asserts while the live results differ from those captured at the last access.
  assign mismatch_o = |diff;

endmodule : cvr_result_latch

// [rtl/cvr_ctrl.sv]
/*
  Control logic of a dual comparator and a 16-level voltage reference, with a
  classic Wishbone register slave and a level interrupt.
  Assumes all inputs are synchronous to clk_i and that the analog parts obey
  the power, mode and tap controls driven here.
*/
// Implementation choices: the address map and the Wishbone interface to the registers.
// Function
// - In sleep an active comparator keeps running and its enabled interrupt wakes the device.
// - Mode 111 switches both comparators off.
// - Waking from sleep leaves the comparator control register unchanged.
// - Reset loads comparator control with its reset value, mode 000.
// - Both comparators stay powered down throughout reset.
// - Reference offers 16 levels in each of two ranges, plus power-down.
// - Range bit picks 0 to 0.625 in 24ths, or 0.25 to 0.71875 in 32nds.
// - Source bit picks the external reference pins, else the supply rails.
// - Four-bit level field takes 0 to 15 and selects the ladder tap.
// - Reference drives its pin only when pin direction is input and output enable set.
// - Reset clears reference enable, output enable, range and level bits.
// - Waking from sleep leaves the reference control register unchanged.
// - Reference works regardless of the comparator mode.
// - Mode 110 routes the internal reference to both positive comparator inputs.
// - Any result change sets the flag, repeatedly until comparator control is accessed.
// - Result bits are read-only; each inverts when its own invert bit is set.
`timescale 1ns/1ps
module cvr_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Analog comparator side
  input wire logic first_comparator_raw_i,
  input wire logic second_comparator_raw_i,
  output logic [1:0] comparator_power_o,
  output logic [2:0] comparator_mode_field_o,
  output logic comparator_input_switch_o,
  output logic reference_to_positive_inputs_o,
  // Resistor ladder side
  output logic reference_power_enable_o,
  output logic reference_range_select_o,
  output logic reference_source_select_o,
  output logic [3:0] reference_level_field_o,
  input wire logic port_f_direction_5_i,
  output logic reference_output_pin_drive_o,
  // Power state and interrupt
  input wire logic sleep_i,
  output logic irq_o,
  output logic comparator_interrupt_priority_o,
  output logic wake_o
);

  logic [7:0] cmp_ctrl_q;
  logic [7:0] ref_ctrl_q;
  logic [7:0] flags_q;
  logic [7:0] enables_q;
  logic [7:0] priority_q;
  logic [1:0] power_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic fire;
  logic wr_fire;
  logic cmp_access;
  logic first_result;
  logic second_result;
  logic mismatch;
  logic [7:0] rd_mux;

  // Register address decode, shared by the write and read paths.
  function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [7:0] ofs);
    hit = (adr[7:0] == ofs);
  endfunction : hit

  // A new request is answered one cycle later; the write lands on the edge
  // at which the master samples ack, so both sides agree on the moment.
  assign req = cyc_i && stb_i && !ack_q;
  assign fire = cyc_i && stb_i && ack_q;
  assign wr_fire = fire && we_i && sel_i[0];
  assign cmp_access = fire && hit(adr_i, cvr_pkg::CMP_CTRL_OFS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Comparator control; result bits are not stored, so writes cannot touch them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_ctrl_q <= cvr_pkg::CMP_CTRL_RST;
    end else if (wr_fire && hit(adr_i, cvr_pkg::CMP_CTRL_OFS)) begin
      cmp_ctrl_q <= {2'b00, dat_i[5:0]};
    end
  end

  // Sleep has no path into either control register, so a wake finds them intact.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_ctrl_q <= cvr_pkg::REF_CTRL_RST;
    end else if (wr_fire && hit(adr_i, cvr_pkg::REF_CTRL_OFS)) begin
      ref_ctrl_q <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enables_q <= cvr_pkg::ENABLES_RST;
      priority_q <= cvr_pkg::PRIORITY_RST;
    end else begin
      if (wr_fire && hit(adr_i, cvr_pkg::ENABLES_OFS)) begin
        enables_q <= dat_i[7:0] & (8'h01 << cvr_pkg::CMP_IRQ_BIT);
      end
      if (wr_fire && hit(adr_i, cvr_pkg::PRIORITY_OFS)) begin
        priority_q <= dat_i[7:0] & (8'h01 << cvr_pkg::CMP_IRQ_BIT);
      end
    end
  end

  // Polarity-corrected results as software sees them.
  assign first_result = first_comparator_raw_i ^ cmp_ctrl_q[cvr_pkg::FIRST_INVERT_BIT];
  assign second_result = second_comparator_raw_i ^ cmp_ctrl_q[cvr_pkg::SECOND_INVERT_BIT];

  cvr_result_latch #(
    .N(2)
  ) u_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .result_i({second_result, first_result}),
    .capture_i(cmp_access),
    .mismatch_o(mismatch)
  );

  // Writing one clears the flag, but a mismatch in the same cycle wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= cvr_pkg::FLAGS_RST;
    end else begin
      flags_q[cvr_pkg::CMP_IRQ_BIT] <= mismatch ||
        (flags_q[cvr_pkg::CMP_IRQ_BIT] &&
         !(wr_fire && hit(adr_i, cvr_pkg::FLAGS_OFS) && dat_i[cvr_pkg::CMP_IRQ_BIT]));
    end
  end

  // Power follows the mode one cycle late and is forced off by reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_q <= 2'b00;
    end else if (cmp_ctrl_q[cvr_pkg::MODE_MSB:0] == cvr_pkg::CVR_MODE_OFF) begin
      power_q <= 2'b00;
    end else begin
      power_q <= 2'b11;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (1'b1)
      hit(adr_i, cvr_pkg::CMP_CTRL_OFS): rd_mux = {second_result, first_result, cmp_ctrl_q[5:0]};
      hit(adr_i, cvr_pkg::REF_CTRL_OFS): rd_mux = ref_ctrl_q;
      hit(adr_i, cvr_pkg::FLAGS_OFS): rd_mux = flags_q;
      hit(adr_i, cvr_pkg::ENABLES_OFS): rd_mux = enables_q;
      hit(adr_i, cvr_pkg::PRIORITY_OFS): rd_mux = priority_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is captured with the request so it is steady while ack is high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req) begin
      dat_q <= {24'h00_0000, rd_mux};
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;

  assign comparator_power_o = power_q;
  assign comparator_mode_field_o = cmp_ctrl_q[cvr_pkg::MODE_MSB:0];
  assign comparator_input_switch_o = cmp_ctrl_q[cvr_pkg::INPUT_SWITCH_BIT];
  assign reference_to_positive_inputs_o =
    (cmp_ctrl_q[cvr_pkg::MODE_MSB:0] == cvr_pkg::CVR_MODE_INTREF);

  // The ladder decodes range, source and tap; mode plays no part here.
  assign reference_power_enable_o = ref_ctrl_q[cvr_pkg::REF_POWER_BIT];
  assign reference_range_select_o = ref_ctrl_q[cvr_pkg::REF_RANGE_BIT];
  assign reference_source_select_o = ref_ctrl_q[cvr_pkg::REF_SOURCE_BIT];
  assign reference_level_field_o = ref_ctrl_q[cvr_pkg::REF_LEVEL_MSB:0];
  assign reference_output_pin_drive_o =
    port_f_direction_5_i && ref_ctrl_q[cvr_pkg::REF_PIN_OE_BIT];

  assign irq_o = |(flags_q & enables_q);
  assign comparator_interrupt_priority_o = priority_q[cvr_pkg::CMP_IRQ_BIT];
  assign wake_o = sleep_i && irq_o;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_reset_values;
    $past(rst_i) |-> comparator_mode_field_o == 3'b000 && !reference_power_enable_o &&
      !reference_range_select_o && reference_level_field_o == 4'h0 && !reference_output_pin_drive_o;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("control not cleared by reset");

  property p_reset_power;
    $past(rst_i) |-> comparator_power_o == 2'b00;
  endproperty
  a_reset_power: assert property (p_reset_power) else $error("comparators powered during reset");

  property p_off_mode;
    comparator_mode_field_o == 3'b111 ##1 comparator_mode_field_o == 3'b111 |-> comparator_power_o == 2'b00;
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("comparators on in mode 111");

  property p_sleep_keeps_power;
    sleep_i && comparator_mode_field_o != 3'b111 |=> comparator_power_o == 2'b11;
  endproperty
  a_sleep_keeps_power: assert property (p_sleep_keeps_power) else $error("comparator off in sleep");

  property p_wake;
    sleep_i && $past(mismatch) && enables_q[6] |-> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("enabled comparator event did not wake");

  property p_sleep_hold;
    !fire ##0 sleep_i |=> $stable(cmp_ctrl_q) && $stable(ref_ctrl_q);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("control changed without a write");

  property p_flag_set;
    mismatch |=> flags_q[6];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("mismatch did not set flag");

  property p_intref;
    reference_to_positive_inputs_o == (comparator_mode_field_o == 3'b110);
  endproperty
  a_intref: assert property (p_intref) else $error("reference routing wrong for mode");

  property p_pin;
    reference_output_pin_drive_o |-> port_f_direction_5_i && ref_ctrl_q[6];
  endproperty
  a_pin: assert property (p_pin) else $error("reference pin driven without permission");

  property p_ref_write;
    fire && we_i && sel_i[0] && adr_i[7:0] == 8'h04 |=> reference_level_field_o == $past(dat_i[3:0]) &&
      reference_power_enable_o == $past(dat_i[7]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference write not applied");

  property p_result_read;
    req && !we_i && adr_i[7:0] == 8'h00 |=> dat_o[6] == $past(first_comparator_raw_i ^ cmp_ctrl_q[4]);
  endproperty
  a_result_read: assert property (p_result_read) else $error("first result polarity wrong");

  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  // The bus answers every request after exactly one cycle, and only the low byte carries data.
  property p_ack_latency;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("request not answered after one cycle");

  property p_dat_upper;
    ack_o |-> dat_o[31:8] == 24'h00_0000;
  endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("upper read data bits not zero");

  property p_unmapped_read;
    req && !we_i && adr_i[7:0] > 8'h10 |=> dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read returned data");

  property p_cmp_write;
    fire && we_i && sel_i[0] && adr_i[7:0] == 8'h00 |=> comparator_mode_field_o == $past(dat_i[2:0]) &&
      comparator_input_switch_o == $past(dat_i[3]);
  endproperty
  a_cmp_write: assert property (p_cmp_write) else $error("comparator write not applied");

  property p_ref_independent;
    fire && we_i && adr_i[7:0] == 8'h00 |=> $stable(ref_ctrl_q);
  endproperty
  a_ref_independent: assert property (p_ref_independent) else $error("mode write disturbed reference");

  property p_result_ro;
    cmp_ctrl_q[7:6] == 2'b00;
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result bits were stored");

  property p_capture;
    cmp_access ##1 $stable({second_result, first_result}) |-> !mismatch;
  endproperty
  a_capture: assert property (p_capture) else $error("access did not end the mismatch");

  property p_flag_clear;
    wr_fire && adr_i[7:0] == 8'h08 && dat_i[6] && !mismatch |=> !flags_q[6];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write one");

  property p_flag_sticky;
    flags_q[6] && !(wr_fire && adr_i[7:0] == 8'h08 && dat_i[6]) |=> flags_q[6];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without a clear");

  property p_irq_level;
    flags_q[6] && enables_q[6] |-> irq_o;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("enabled flag gave no interrupt");

  property p_no_wake_awake;
    !sleep_i |-> !wake_o;
  endproperty
  a_no_wake_awake: assert property (p_no_wake_awake) else $error("wake raised while awake");

  property p_power_modes;
    comparator_mode_field_o != 3'b111 |=> comparator_power_o == 2'b11;
  endproperty
  a_power_modes: assert property (p_power_modes) else $error("comparators off outside mode 111");

  c_wake: cover property (sleep_i ##1 wake_o);
  c_intref: cover property (comparator_mode_field_o == 3'b110 && reference_power_enable_o);
  c_flag_clear: cover property (flags_q[6] ##1 !flags_q[6]);
  c_off_mode: cover property (comparator_mode_field_o == 3'b111 ##1 comparator_power_o == 2'b00);
  c_pin_drive: cover property (reference_output_pin_drive_o);

endmodule : cvr_ctrl

// [bench/cvr_analog_model.sv]
/*
  Behavioural model of the two analog comparators fed by the resistor ladder.
  Assumes the bench sets each comparator's input difference as a logic level.
*/
`timescale 1ns/1ps
module cvr_analog_model (
  // Controls from the block
  input wire logic [1:0] comparator_power_i,
  input wire logic reference_to_positive_inputs_i,
  input wire logic [3:0] reference_level_field_i,
  // Input levels chosen by the bench
  input wire logic [1:0] level_i,
  // Comparator outputs
  output logic first_raw_o,
  output logic second_raw_o
);
  logic [1:0] diff;
  // With the ladder on both positive inputs, upper taps beat the mid-rail minus input.
  assign diff = reference_to_positive_inputs_i ? {2{reference_level_field_i[3]}} : level_i;
  // A powered-down comparator gives a low output.
  assign first_raw_o = comparator_power_i[0] & diff[0];
  assign second_raw_o = comparator_power_i[1] & diff[1];
endmodule : cvr_analog_model

// [bench/tb_top.sv]
/*
  Self-checking testbench of the comparator and reference control block.
  Assumes the Wishbone slave answers each request once and one raw input per
  comparator driven by the analog model.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o, raw1, raw2, mode6, rpe, rrs, rss, comparator_input_switch, drv, irq_o, prio, wake_o;
  logic dir_i = 1'b1;
  logic sleep_i = 1'b0;
  logic [1:0] lvl = 2'b00;
  logic [1:0] pwr;
  logic [2:0] mode;
  logic [3:0] rlev;
  logic [7:0] v;
  int fails = 0;
  int comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  cvr_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .first_comparator_raw_i(raw1),
    .second_comparator_raw_i(raw2), .comparator_power_o(pwr), .comparator_mode_field_o(mode),
    .comparator_input_switch_o(comparator_input_switch), .reference_to_positive_inputs_o(mode6), .reference_power_enable_o(rpe),
    .reference_range_select_o(rrs), .reference_source_select_o(rss), .reference_level_field_o(rlev),
    .port_f_direction_5_i(dir_i), .reference_output_pin_drive_o(drv), .sleep_i(sleep_i), .irq_o(irq_o),
    .comparator_interrupt_priority_o(prio), .wake_o(wake_o));

  cvr_analog_model MDL (.comparator_power_i(pwr), .reference_to_positive_inputs_i(mode6),
    .reference_level_field_i(rlev), .level_i(lvl), .first_raw_o(raw1), .second_raw_o(raw2));

  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chb(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : chb

  // One classic cycle; the caller stands just after a rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      fails++;
      end_of_test();
    end
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(r, {24'h00_0000, e});
  endtask : rd

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    chk({30'h0, pwr}, 32'h0000_0000);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h10, 8'h40);
    chb(prio, 1'b1);
    wr(8'h10, 8'h00);
    rd(8'h10, 8'h00);
    chb(prio, 1'b0);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], i[3:0]};
      dir_i <= i[1];
      wr(8'h04, v);
      rd(8'h04, v);
      chk({25'h0, rpe, rrs, rss, rlev}, {25'h0, v[7], v[5:0]});
      chb(drv, v[6] & i[1]);
    end
    wr(8'h04, 8'hf0);
    for (int m = 0; m < 8; m++) begin
      wr(8'h00, {4'h0, m[0], m[2:0]});
      rd(8'h00, {4'h0, m[0], m[2:0]});
      chk({29'h0, mode}, m);
      chb(comparator_input_switch, m[0]);
      chk({30'h0, pwr}, (m == 7) ? 32'h0000_0000 : 32'h0000_0003);
      chb(mode6, m == 6);
      chb(rpe, 1'b1);
    end
    wr(8'h04, 8'hff);
    wr(8'h00, 8'h06);
    rd(8'h00, 8'hc6);
    wr(8'h04, 8'hf0);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h40);
    wr(8'h0c, 8'h40);
    lvl <= 2'b01;
    repeat (3) @(posedge clk_i);
    chb(irq_o, 1'b1);
    wr(8'h08, 8'h40);
    rd(8'h08, 8'h40);
    rd(8'h00, 8'h40);
    wr(8'h08, 8'h40);
    rd(8'h08, 8'h00);
    chb(irq_o, 1'b0);
    wr(8'h00, 8'hd0);
    rd(8'h00, 8'h10);
    wr(8'h08, 8'h40);
    wr(8'h0c, 8'h00);
    lvl <= 2'b11;
    repeat (3) @(posedge clk_i);
    chb(irq_o, 1'b0);
    rd(8'h08, 8'h40);
    sleep_i <= 1'b1;
    wr(8'h0c, 8'h40);
    chb(wake_o, 1'b1);
    chb(irq_o, 1'b1);
    sleep_i <= 1'b0;
    @(posedge clk_i);
    chb(wake_o, 1'b0);
    rd(8'h00, 8'h90);
    rd(8'h04, 8'hf0);
    lvl <= 2'b00;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({30'h0, pwr}, 32'h0000_0000);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    end_of_test();
  end
endmodule : tb_top
